//--- pcas_pkg.sv
// Constants, codes and types shared by the sequencer and its serial shifter
package pcas_pkg;

  // Clock and output data rates
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned ODR_A_HZ      = 10;
  localparam int unsigned ODR_B_HZ      = 50;
  localparam int unsigned ODR_C_HZ      = 60;
  localparam int unsigned ODR_D_HZ      = 120;
  localparam int unsigned PER_A_CYC     = CLK_HZ / ODR_A_HZ;
  localparam int unsigned PER_B_CYC     = CLK_HZ / ODR_B_HZ;
  localparam int unsigned PER_C_CYC     = CLK_HZ / ODR_C_HZ;
  localparam int unsigned PER_D_CYC     = CLK_HZ / ODR_D_HZ;

  // Settling is counted in whole conversion periods
  localparam int unsigned SETTLE_CONV   = 4;
  localparam logic [2:0]  SETTLE_LAST   = 3'(SETTLE_CONV - 1);

  // Ready line returns high this long before an unread word is replaced
  localparam int unsigned RDY_LEAD_NS   = 10_000;
  localparam int unsigned RDY_LEAD_CYC  = RDY_LEAD_NS / CLK_PERIOD_NS;

  // Widths
  localparam int unsigned CNT_W  = 21;
  localparam int unsigned WORD_W = 24;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BITS_W = 5;
  localparam logic [BITS_W-1:0] WORD_BITS = 5'h18;

  // Rate-select codes {hi, lo}
  localparam logic [1:0] RATE_10HZ  = 2'h3;
  localparam logic [1:0] RATE_50HZ  = 2'h2;
  localparam logic [1:0] RATE_60HZ  = 2'h1;
  localparam logic [1:0] RATE_120HZ = 2'h0;

  // Gain-select codes {hi, lo} and gain values
  localparam logic [1:0] GAIN_CODE_1   = 2'h0;
  localparam logic [1:0] GAIN_CODE_8   = 2'h1;
  localparam logic [1:0] GAIN_CODE_64  = 2'h2;
  localparam logic [1:0] GAIN_CODE_128 = 2'h3;
  localparam logic [7:0] GAIN_VAL_1    = 8'h01;
  localparam logic [7:0] GAIN_VAL_8    = 8'h08;
  localparam logic [7:0] GAIN_VAL_64   = 8'h40;
  localparam logic [7:0] GAIN_VAL_128  = 8'h80;

  // Register map
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] REG_DATA = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CONV = 8'h0C;
  localparam int unsigned CTRL_EN_BIT      = 0;
  localparam int unsigned CTRL_RESTART_BIT = 1;
  localparam logic        CTRL_EN_RST      = 1'b1;

  typedef enum logic [1:0] {
    PCAS_SRC_PAIR_A,
    PCAS_SRC_PAIR_B,
    PCAS_SRC_TEMP
  } pcas_src_t;

  typedef enum logic [1:0] {
    PCAS_ST_IDLE,
    PCAS_ST_SETTLE,
    PCAS_ST_RUN
  } pcas_state_t;

endpackage

//--- pcas_ser_if.sv
// Link between the conversion sequencer and the serial output shifter
`timescale 1ns/10ps
interface pcas_ser_if;
  logic                        load;
  logic                        abort;
  logic                        expire;
  logic                        sclk_rise;
  logic                        sclk_fall;
  logic [pcas_pkg::WORD_W-1:0] word;
  logic                        line;
  logic                        ready;
  logic                        done;

  modport seq (
    output load,
    output abort,
    output expire,
    output sclk_rise,
    output sclk_fall,
    output word,
    input  line,
    input  ready,
    input  done
  );

  modport shf (
    input  load,
    input  abort,
    input  expire,
    input  sclk_rise,
    input  sclk_fall,
    input  word,
    output line,
    output ready,
    output done
  );
endinterface

//--- pcas_shifter.sv
// Serial output shifter driving the shared ready/data line
`timescale 1ns/10ps
module pcas_shifter (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Sequencer side
  pcas_ser_if.shf   ser
);

  logic [pcas_pkg::WORD_W-1:0] sh_q;
  logic [pcas_pkg::BITS_W-1:0] cnt_q;
  logic                        ready_q;
  logic                        line_q;
  logic                        done_q;

  assign ser.line  = line_q;
  assign ser.ready = ready_q;
  assign ser.done  = done_q;

  // Restart beats a new word, which beats expiry and shifting
  always_ff @(posedge clk) begin
    if (rst) begin
      sh_q    <= '0;
      cnt_q   <= '0;
      ready_q <= 1'b0;
      line_q  <= 1'b1;
    end else if (ser.abort) begin
      ready_q <= 1'b0; // R3
      line_q  <= 1'b1; // R5
    end else if (ser.load) begin
      sh_q    <= ser.word;
      cnt_q   <= '0;
      ready_q <= 1'b1;
      line_q  <= 1'b0; // R16
    end else if (ser.expire) begin
      ready_q <= 1'b0;
      line_q  <= 1'b1; // R18
    end else if (ready_q && ser.sclk_fall && cnt_q != pcas_pkg::WORD_BITS) begin
      line_q <= sh_q[pcas_pkg::WORD_W-1]; // R17
      sh_q   <= {sh_q[pcas_pkg::WORD_W-2:0], 1'b0};
      cnt_q  <= cnt_q + 5'h01;
    end else if (ready_q && ser.sclk_rise && cnt_q == pcas_pkg::WORD_BITS) begin
      // Each word is read once only
      ready_q <= 1'b0;
      line_q  <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= !ser.abort && !ser.load && !ser.expire && ready_q && ser.sclk_rise
                && cnt_q == pcas_pkg::WORD_BITS;
    end
  end

endmodule

//--- pcas_sequencer.sv
// Pin-configured conversion sequencer with settling control and serial readout
`timescale 1ns/10ps
// Contract
// R1: Rate pins 11,10,01,00 give 10/50/60/120 Hz
// R2: Settling lasts four conversion periods
// R3: Rate change restarts filter, forces line high
// R4: First result after settling, then each period
// R5: Line high while settling; host reads ones
// R6: Gain pins 00,01,10,11 give 1/8/64/128
// R7: Gain change restarts filter, line held high
// R8: After gain change, first result after settling
// R9: Pair select low: pair A, high: B
// R10: Channel change forces line high until settled
// R11: Temperature select overrides the pair select
// R12: Selecting temperature forces line high, settling
// R13: Temperature result offset binary from 0x800000
// R14: Every completed conversion loads data register
// R15: Host discards results after input steps
// R16: Line goes low when result ready
// R17: Bits change on falling serial clock edge
// R18: Unread result: line high before next update
// R19: Results are offset binary coded
// R20: Synchronise pins; any difference restarts filter (a pair select change while temp_sel is high does not restart)
module pcas_sequencer #(
  parameter int unsigned PER_A_CYC = pcas_pkg::PER_A_CYC,
  parameter int unsigned PER_B_CYC = pcas_pkg::PER_B_CYC,
  parameter int unsigned PER_C_CYC = pcas_pkg::PER_C_CYC,
  parameter int unsigned PER_D_CYC = pcas_pkg::PER_D_CYC
) (
  // Clock and reset
  input  wire  logic                          clk,
  input  wire  logic                          rst,
  // Configuration pins
  input  wire  logic                          rate_sel_lo,
  input  wire  logic                          rate_sel_hi,
  input  wire  logic                          gain_sel_lo,
  input  wire  logic                          gain_sel_hi,
  input  wire  logic                          input_pair_sel,
  input  wire  logic                          temp_sel,
  // Serial link
  input  wire  logic                          sclk,
  output logic                                dout_rdy,
  // Analog front end and filter
  output pcas_pkg::pcas_src_t                 fe_src,
  output logic [7:0]                          fe_gain,
  output logic                                mod_filt_rst,
  input  wire  logic [pcas_pkg::WORD_W-1:0]   conv_data,
  // Register port
  input  wire  logic [pcas_pkg::ADDR_W-1:0]   reg_addr,
  input  wire  logic [pcas_pkg::DATA_W-1:0]   reg_wdata,
  input  wire  logic                          reg_wr,
  input  wire  logic                          reg_rd,
  output logic [pcas_pkg::DATA_W-1:0]         reg_rdata
);

  localparam int unsigned NSYNC = 7;
  // Serial clock rests high; resetting its chain low would fake an edge
  localparam logic [NSYNC-1:0] SYNC_RST = 7'h40;

  // Period of one conversion for a rate code
  function automatic logic [pcas_pkg::CNT_W-1:0] rate_period(input logic [1:0] code);
    logic [pcas_pkg::CNT_W-1:0] p;
    p = '0;
    case (code)
      pcas_pkg::RATE_10HZ:  p = pcas_pkg::CNT_W'(PER_A_CYC);
      pcas_pkg::RATE_50HZ:  p = pcas_pkg::CNT_W'(PER_B_CYC);
      pcas_pkg::RATE_60HZ:  p = pcas_pkg::CNT_W'(PER_C_CYC);
      default:              p = pcas_pkg::CNT_W'(PER_D_CYC);
    endcase
    return p; // R1
  endfunction

  // Gain value for a gain code
  function automatic logic [7:0] gain_value(input logic [1:0] code);
    logic [7:0] g;
    g = '0;
    case (code)
      pcas_pkg::GAIN_CODE_1:  g = pcas_pkg::GAIN_VAL_1;
      pcas_pkg::GAIN_CODE_8:  g = pcas_pkg::GAIN_VAL_8;
      pcas_pkg::GAIN_CODE_64: g = pcas_pkg::GAIN_VAL_64;
      default:                g = pcas_pkg::GAIN_VAL_128;
    endcase
    return g; // R6
  endfunction

  // Two-stage synchronisers for every asynchronous pin
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;

  assign pin_raw = {sclk, temp_sel, input_pair_sel, gain_sel_hi, gain_sel_lo,
                    rate_sel_hi, rate_sel_lo};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_q[gi] <= SYNC_RST[gi];
          sync_q[gi] <= SYNC_RST[gi];
        end else begin
          meta_q[gi] <= pin_raw[gi];
          sync_q[gi] <= meta_q[gi]; // R20
        end
      end
    end
  endgenerate

  // Decoded configuration
  logic [1:0]          rate_code;
  logic [1:0]          gain_code;
  pcas_pkg::pcas_src_t src_d;
  logic [5:0]          cfg_d;

  assign rate_code = sync_q[1:0];
  assign gain_code = sync_q[3:2];

  always_comb begin
    if (sync_q[5]) begin
      src_d = pcas_pkg::PCAS_SRC_TEMP; // R11
    end else if (sync_q[4]) begin
      src_d = pcas_pkg::PCAS_SRC_PAIR_B; // R9
    end else begin
      src_d = pcas_pkg::PCAS_SRC_PAIR_A;
    end
  end

  // Pair select is ignored while the sensor is routed, so it cannot restart
  assign cfg_d = {src_d, gain_code, rate_code};

  logic [5:0] cfg_prev_q;
  logic       primed_q;
  logic       cfg_change;

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_prev_q <= '0;
      primed_q   <= 1'b0;
    end else begin
      cfg_prev_q <= cfg_d;
      primed_q   <= 1'b1;
    end
  end

  assign cfg_change = primed_q && (cfg_d != cfg_prev_q); // R20 R3 R7 R10 R12

  // Serial clock edges from the synchronised copy only
  logic sclk_old_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_old_q <= 1'b1;
    end else begin
      sclk_old_q <= sync_q[6];
    end
  end

  // Control register
  logic ctrl_en_q;
  logic soft_restart;
  logic en_old_q;
  logic restart;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_en_q <= pcas_pkg::CTRL_EN_RST;
    end else if (reg_wr && reg_addr == pcas_pkg::REG_CTRL) begin
      ctrl_en_q <= reg_wdata[pcas_pkg::CTRL_EN_BIT];
    end
  end

  assign soft_restart = reg_wr && reg_addr == pcas_pkg::REG_CTRL
                        && reg_wdata[pcas_pkg::CTRL_RESTART_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      en_old_q <= 1'b0;
    end else begin
      en_old_q <= ctrl_en_q && primed_q;
    end
  end

  // Any decoded configuration change, software restart or re-enable starts afresh
  assign restart = ctrl_en_q && primed_q && (cfg_change || soft_restart || !en_old_q);

  // Sequencing state
  pcas_pkg::pcas_state_t      state_q;
  logic [pcas_pkg::CNT_W-1:0] per_q;
  logic [pcas_pkg::CNT_W-1:0] tick_q;
  logic [2:0]                 settle_q;
  logic                       period_end;
  logic                       load;
  logic                       expire;

  assign period_end = (tick_q == per_q - 21'h000001);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q  <= pcas_pkg::PCAS_ST_IDLE;
      per_q    <= pcas_pkg::CNT_W'(PER_D_CYC);
      tick_q   <= '0;
      settle_q <= '0;
    end else if (!ctrl_en_q) begin
      state_q <= pcas_pkg::PCAS_ST_IDLE;
      tick_q  <= '0;
    end else if (restart) begin
      state_q  <= pcas_pkg::PCAS_ST_SETTLE; // R3
      per_q    <= rate_period(rate_code); // R1
      tick_q   <= '0;
      settle_q <= '0;
    end else begin
      case (state_q)
        pcas_pkg::PCAS_ST_SETTLE: begin
          if (period_end) begin
            tick_q <= '0;
            if (settle_q == pcas_pkg::SETTLE_LAST) begin
              state_q <= pcas_pkg::PCAS_ST_RUN; // R2 R4 R8
            end else begin
              settle_q <= settle_q + 3'h1;
            end
          end else begin
            tick_q <= tick_q + 21'h000001;
          end
        end
        pcas_pkg::PCAS_ST_RUN: begin
          if (period_end) begin
            tick_q <= '0; // R4
          end else begin
            tick_q <= tick_q + 21'h000001;
          end
        end
        default: begin
          tick_q <= '0;
        end
      endcase
    end
  end

  // Settling ends with a result; running loads one per period
  assign load = ctrl_en_q && !restart && period_end
                && ((state_q == pcas_pkg::PCAS_ST_SETTLE && settle_q == pcas_pkg::SETTLE_LAST)
                    || state_q == pcas_pkg::PCAS_ST_RUN); // R14

  // Lead assumes the period exceeds the lead time by a wide margin
  assign expire = state_q == pcas_pkg::PCAS_ST_RUN && !restart
                  && tick_q == per_q - pcas_pkg::CNT_W'(pcas_pkg::RDY_LEAD_CYC) - 21'h000001; // R18

  // Front-end controls follow the live selection
  always_ff @(posedge clk) begin
    if (rst) begin
      fe_src       <= pcas_pkg::PCAS_SRC_PAIR_A;
      fe_gain      <= pcas_pkg::GAIN_VAL_1;
      mod_filt_rst <= 1'b1;
    end else begin
      fe_src       <= src_d; // R11 R13
      fe_gain      <= gain_value(gain_code); // R6
      mod_filt_rst <= restart || !ctrl_en_q; // R3 R7
    end
  end

  // Data register: offset binary words pass through unchanged
  logic [pcas_pkg::WORD_W-1:0] result_q;
  logic [15:0]                 conv_cnt_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      result_q <= '0;
    end else if (load) begin
      result_q <= conv_data; // R14 R19
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      conv_cnt_q <= '0;
    end else if (load) begin
      conv_cnt_q <= conv_cnt_q + 16'h0001;
    end
  end

  // Serial shifter
  pcas_ser_if ser ();

  assign ser.load      = load;
  assign ser.abort     = restart || !ctrl_en_q; // R5 R10 R12
  assign ser.expire    = expire;
  assign ser.sclk_rise = sync_q[6] && !sclk_old_q;
  assign ser.sclk_fall = !sync_q[6] && sclk_old_q; // R17
  assign ser.word      = conv_data;

  pcas_shifter u_shifter (
    .clk (clk),
    .rst (rst),
    .ser (ser.shf)
  );

  assign dout_rdy = ser.line;

  // Last word fully clocked out; set beats a same-cycle clear
  logic read_ok_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      read_ok_q <= 1'b0;
    end else if (ser.done) begin
      read_ok_q <= 1'b1;
    end else if (ser.load || ser.abort) begin
      read_ok_q <= 1'b0;
    end
  end

  // Register reads, one cycle after the strobe
  logic [pcas_pkg::DATA_W-1:0] stat_word;

  // Status: run, settle, pending, read out, spare, rate, gain, source
  assign stat_word = {19'h00000,
                      fe_src, gain_code, rate_code,
                      3'h0, read_ok_q, ser.ready,
                      state_q == pcas_pkg::PCAS_ST_SETTLE,
                      state_q == pcas_pkg::PCAS_ST_RUN};

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == pcas_pkg::REG_CTRL) begin
        reg_rdata <= {31'h00000000, ctrl_en_q};
      end else if (reg_addr == pcas_pkg::REG_STAT) begin
        reg_rdata <= stat_word;
      end else if (reg_addr == pcas_pkg::REG_DATA) begin
        reg_rdata <= {8'h00, result_q};
      end else if (reg_addr == pcas_pkg::REG_CONV) begin
        reg_rdata <= {16'h0000, conv_cnt_q};
      end else begin
        reg_rdata <= '0;
      end
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

//--- pcas_sequencer_props.sv
// Port-level checks for the conversion sequencer
`timescale 1ns/10ps
module pcas_sequencer_props #(
  parameter int unsigned PER_A_CYC = 1200,
  parameter int unsigned PER_B_CYC = 1000,
  parameter int unsigned PER_C_CYC = 900,
  parameter int unsigned PER_D_CYC = 800
) (
  // Clock and reset
  input wire logic                clk,
  input wire logic                rst,
  // Configuration pins
  input wire logic                rate_sel_lo,
  input wire logic                rate_sel_hi,
  input wire logic                gain_sel_lo,
  input wire logic                gain_sel_hi,
  input wire logic                input_pair_sel,
  input wire logic                temp_sel,
  // Observed outputs
  input wire logic                dout_rdy,
  input wire pcas_pkg::pcas_src_t fe_src,
  input wire logic [7:0]          fe_gain,
  input wire logic                mod_filt_rst
);
  logic [1:0]          rate_c;
  logic [1:0]          gain_c;
  logic [7:0]          gain_v;
  pcas_pkg::pcas_src_t src_v;
  int unsigned         per;
  int unsigned         since_q;
  int unsigned         low_q;
  logic                fresh_q;

  assign rate_c = {rate_sel_hi, rate_sel_lo};
  assign gain_c = {gain_sel_hi, gain_sel_lo};
  assign per    = rate_c == 2'h3 ? PER_A_CYC : rate_c == 2'h2 ? PER_B_CYC : rate_c == 2'h1 ? PER_C_CYC : PER_D_CYC;
  assign gain_v = gain_c == 2'h0 ? 8'h01 : gain_c == 2'h1 ? 8'h08 : gain_c == 2'h2 ? 8'h40 : 8'h80;
  assign src_v  = temp_sel ? pcas_pkg::PCAS_SRC_TEMP : input_pair_sel ? pcas_pkg::PCAS_SRC_PAIR_B
                                                                      : pcas_pkg::PCAS_SRC_PAIR_A;

  // Cycles since the last restart
  always_ff @(posedge clk) begin
    since_q <= (rst || mod_filt_rst) ? 0 : since_q + 1;
  end
  // Length of the current low run of the line
  always_ff @(posedge clk) begin
    low_q <= (rst || dout_rdy) ? 0 : low_q + 1;
  end
  // Set until the first word after a restart is flagged
  always_ff @(posedge clk) begin
    fresh_q <= rst || mod_filt_rst || (fresh_q && dout_rdy);
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence cfg_moved_s;
    $changed({rate_c, gain_c, temp_sel});
  endsequence
  sequence restart_s;
    mod_filt_rst ##1 dout_rdy [*8];
  endsequence

  cfg_restart_a: assert property (cfg_moved_s |-> ##[1:6] restart_s)
    else $error("config change without restart");
  pair_restart_a: assert property ($changed(input_pair_sel) && !temp_sel |-> ##[1:6] restart_s)
    else $error("pair change without restart");
  pair_masked_a: assert property ((temp_sel && $stable({rate_c, gain_c})) [*8] ##0 $changed(input_pair_sel)
    |=> !mod_filt_rst [*4])
    else $error("pair change restarted under temperature");
  settle_hold_a: assert property (since_q + 2 < 4 * per |-> dout_rdy)
    else $error("line low during settling");
  first_load_a: assert property (fresh_q && !dout_rdy |-> since_q inside {[4*per-2:4*per+3]})
    else $error("first word at wrong time");
  unread_high_a: assert property (low_q + 200 <= per)
    else $error("line low into next update");
  gain_map_a: assert property ($stable(gain_c) [*8] |-> fe_gain == gain_v)
    else $error("gain decode wrong");
  src_map_a: assert property ($stable({temp_sel, input_pair_sel}) [*8] |-> fe_src == src_v)
    else $error("source decode wrong");
endmodule

//--- pcas_host_model.sv
// Host side: clocks result words off the ready/data line
`timescale 1ns/10ps
module pcas_host_model (
  // Serial link
  output logic      sclk,
  input  wire logic dout_rdy
);
  // Clock rests high between frames
  initial sclk = 1'b1;

  task automatic read_word(output logic [23:0] w);
    // Keep serial clock edges off the system clock edges
    #10;
    for (int i = 0; i < 24; i++) begin
      #200 sclk = 1'b0;
      #200 sclk = 1'b1;
      w = {w[22:0], dout_rdy};
    end
  endtask
endmodule

//--- testbench.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/10ps
module testbench;
  localparam int unsigned PA = 1200;
  localparam int unsigned PB = 1000;
  localparam int unsigned PC = 900;
  localparam int unsigned PD = 800;
  logic                clk       = 1'b0;
  logic                rst       = 1'b1;
  logic [1:0]          rate_c    = 2'h0;
  logic [1:0]          gain_c    = 2'h0;
  logic                pair_sel  = 1'b0;
  logic                temp_sel  = 1'b0;
  logic [23:0]         conv_data = 24'h0;
  logic [7:0]          reg_addr  = 8'h0;
  logic [31:0]         reg_wdata = 32'h0;
  logic                reg_wr    = 1'b0;
  logic                reg_rd    = 1'b0;
  logic                sclk;
  logic                dout_rdy;
  pcas_pkg::pcas_src_t fe_src;
  logic [7:0]          fe_gain;
  logic                mod_filt_rst;
  logic [31:0]         reg_rdata;
  logic [23:0]         w;
  logic [31:0]         d;
  int                  err_total = 0;
  int                  checks    = 0;
  int                  cyc       = 0;
  int                  t0;

  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  pcas_sequencer #(.PER_A_CYC(PA), .PER_B_CYC(PB), .PER_C_CYC(PC), .PER_D_CYC(PD)) pcas_sequencer_i (
    .clk(clk), .rst(rst), .rate_sel_lo(rate_c[0]), .rate_sel_hi(rate_c[1]), .gain_sel_lo(gain_c[0]),
    .gain_sel_hi(gain_c[1]), .input_pair_sel(pair_sel), .temp_sel(temp_sel), .sclk(sclk),
    .dout_rdy(dout_rdy), .fe_src(fe_src), .fe_gain(fe_gain), .mod_filt_rst(mod_filt_rst),
    .conv_data(conv_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  pcas_host_model pcas_host_model_i (.sclk(sclk), .dout_rdy(dout_rdy));

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("[ERR] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // Bounded wait on the restart pulse (rs=1) or the line level
  task automatic wait_lvl(input logic rs, input logic v, input int lim);
    int n;
    n = 0;
    while ((rs ? mod_filt_rst : dout_rdy) !== v) begin
      @(posedge clk);
      n++;
      if (n > lim) begin
        err_total++;
        $display("[ERR] %0t wait timed out", $time);
        stop_test();
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic t_rates();
    int          per[4]    = '{PD, PC, PB, PA};
    logic [23:0] val[4]    = '{24'h800000, 24'h000000, 24'hFFFFFF, 24'hA5C3E1};
    for (int k = 3; k >= 0; k--) begin
      @(posedge clk);
      rate_c    <= 2'(k);
      conv_data <= val[k];
      wait_lvl(1'b1, 1'b1, 20);
      t0 = cyc;
      wait_lvl(1'b0, 1'b0, 6000);
      chk_rng(cyc - t0, 4 * per[k], 4 * per[k] + 3);
      t0 = cyc;
      pcas_host_model_i.read_word(w);
      chk_val(32'(w), 32'(val[k]));
      wait_lvl(1'b0, 1'b1, 50);
      wait_lvl(1'b0, 1'b0, 2000);
      chk_rng(cyc - t0, per[k], per[k]);
      pcas_host_model_i.read_word(w);
      chk_val(32'(w), 32'(val[k]));
    end
    $display("t_rates done");
  endtask

  task automatic t_regs();
    rd(pcas_pkg::REG_CTRL, d);
    chk_val(d, 32'h00000001);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, d);
    chk_val(d, 32'h00000000);
    rd(pcas_pkg::REG_STAT, d);
    chk_val(32'(d[10:7]), 32'({gain_c, rate_c}));
    chk_val(32'(d[3:0]), 32'h00000009);
    rd(pcas_pkg::REG_DATA, d);
    chk_val(d, 32'h00800000);
    wr(pcas_pkg::REG_CTRL, 32'h00000003);
    wait_lvl(1'b1, 1'b1, 10);
    $display("t_regs done");
  endtask

  // Unread word: line must rise ahead of the next update
  task automatic t_unread();
    logic [31:0] c;
    rd(pcas_pkg::REG_CONV, c);
    wait_lvl(1'b0, 1'b0, 6000);
    t0 = cyc;
    rd(pcas_pkg::REG_CONV, d);
    chk_val(d, c + 32'h00000001);
    wait_lvl(1'b0, 1'b1, 2000);
    chk_rng(cyc - t0, PD - 203, PD - 200);
    $display("t_unread done");
  endtask

  task automatic t_gains();
    logic [7:0] gv[4] = '{8'h01, 8'h08, 8'h40, 8'h80};
    for (int k = 1; k <= 4; k++) begin
      @(posedge clk);
      gain_c <= 2'(k % 4);
      wait_lvl(1'b1, 1'b1, 20);
      repeat (3) @(posedge clk);
      chk_val(32'(fe_gain), 32'(gv[k % 4]));
      chk_val(32'(dout_rdy), 32'h1);
    end
    t0 = cyc;
    wait_lvl(1'b0, 1'b0, 6000);
    chk_rng(cyc - t0, 4 * PD - 3, 4 * PD + 3);
    pcas_host_model_i.read_word(w);
    chk_val(32'(w), 32'h00800000);
    $display("t_gains done");
  endtask

  task automatic t_src();
    logic [1:0]          pin[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    pcas_pkg::pcas_src_t src[4] = '{pcas_pkg::PCAS_SRC_PAIR_A, pcas_pkg::PCAS_SRC_TEMP,
                                    pcas_pkg::PCAS_SRC_TEMP, pcas_pkg::PCAS_SRC_PAIR_B};
    logic                rs[4]  = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic                seen;
    for (int k = 3; k >= 0; k--) begin
      @(posedge clk);
      {pair_sel, temp_sel} <= pin[k];
      seen = 1'b0;
      repeat (10) begin
        @(posedge clk);
        seen |= mod_filt_rst;
      end
      chk_val(32'(seen), 32'(rs[k]));
      chk_val(32'(fe_src), 32'(src[k]));
    end
    $display("t_src done");
  endtask

  // Gain change in mid-read: the rest of the word reads as ones
  task automatic t_midread();
    wait_lvl(1'b0, 1'b0, 6000);
    fork
      pcas_host_model_i.read_word(w);
      begin
        repeat (60) @(posedge clk);
        gain_c <= 2'h1;
      end
    join
    chk_val(32'(w[15:0]), 32'h0000FFFF);
    $display("t_midread done");
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    t_rates();
    t_regs();
    t_unread();
    t_gains();
    t_src();
    t_midread();
    stop_test();
  end
endmodule

bind pcas_sequencer pcas_sequencer_props #(
  .PER_A_CYC(PER_A_CYC), .PER_B_CYC(PER_B_CYC), .PER_C_CYC(PER_C_CYC), .PER_D_CYC(PER_D_CYC)
) pcas_sequencer_props_i (
  .clk(clk), .rst(rst), .rate_sel_lo(rate_sel_lo), .rate_sel_hi(rate_sel_hi), .gain_sel_lo(gain_sel_lo),
  .gain_sel_hi(gain_sel_hi), .input_pair_sel(input_pair_sel), .temp_sel(temp_sel), .dout_rdy(dout_rdy),
  .fe_src(fe_src), .fe_gain(fe_gain), .mod_filt_rst(mod_filt_rst)
);
